// file: verilog/mrs_cfg.svh
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH
// ==========================================================================
// Widths.
`define MRS_W 18
`define MRS_PC_W 13
`define MRS_CMA_W 6
`define MRS_UB_W 15
`define MRS_UW_W 21
// ==========================================================================
// Micro-operation masks within the low bits of a process word.
`define MRS_M_CNT_DRV 15'h0001
`define MRS_M_OPR_LD 15'h0002
`define MRS_M_OPR_DRV 15'h0004
`define MRS_M_BUF_B 15'h0008
`define MRS_M_O_BUF 15'h0010
`define MRS_M_CNT_LD 15'h0020
`define MRS_M_FLAG_CAP 15'h0040
`define MRS_M_SKIP_SET 15'h0080
`define MRS_M_JMP_INC 15'h0100
`define MRS_M_DEFER 15'h0200
`define MRS_M_IND_TEST 15'h0400
`define MRS_M_WAIT_CLK 15'h0800
`define MRS_M_CHAIN 15'h1000
`define MRS_M_DONE 15'h2000
`define MRS_M_PLUS1 15'h4000
// ==========================================================================
// Control memory locations and address modifiers.
`define MRS_A_BEGIN 6'h08
`define MRS_A_FETCH 6'h11
`define MRS_A_IA0_2 6'h13
`define MRS_A_OPSEL 6'h14
`define MRS_A_EXEC 6'h18
`define MRS_A_IA0 6'h1A
`define MRS_A_IRSEL 6'h30
`define MRS_A_SUBR 6'h32
`define MRS_A_ISZ 6'h39
`define MRS_A_JMP 6'h3C
`define MRS_MOD_ISZ 6'h09
`define MRS_MOD_JMS 6'h02
`define MRS_MOD_JMP 6'h0C
`define MRS_MOD_TI 6'h02
`define MRS_SEL_HI 2'h3
// ==========================================================================
// Opcodes in instruction bits 0-3.
`define MRS_OP_ISZ 4'h9
`define MRS_OP_JMP 4'hC
`define MRS_OP_JMS 4'h2
// ==========================================================================
// Register map and timing.
`define MRS_R_INSTR 12'h000
`define MRS_R_PC 12'h004
`define MRS_R_STATUS 12'h008
`define MRS_R_MODE 12'h00C
`define MRS_CMCLK_DIV 4
`endif

// file: verilog/mrs_pkg.sv
package mrs_pkg;
    typedef enum logic [1:0] {
        MRS_IDLE = 2'h0,
        MRS_RUN = 2'h1,
        MRS_WCLK = 2'h3,
        MRS_WMEM = 2'h2
    } mrs_state_e;
    typedef logic [17:0] mrs_word_t;
    typedef logic [12:0] mrs_addr_t;
    typedef logic [5:0] mrs_cma_t;
    typedef logic [20:0] mrs_uword_t;
endpackage : mrs_pkg

// file: verilog/mrs_ctrl_rom.sv
`timescale 1ns/10ps
`include "mrs_cfg.svh"
module mrs_ctrl_rom (
    input wire mrs_pkg::mrs_cma_t i_cma,
    output mrs_pkg::mrs_uword_t o_uword
);
    import mrs_pkg::*;

    function automatic mrs_uword_t uw(input logic [14:0] ops, input mrs_cma_t nxt);
        uw = {nxt, ops};
    endfunction : uw

    // ======================================================================
    // Process words: micro-operation enables and a next address.
    always_comb begin
        case (i_cma)
            `MRS_A_BEGIN: o_uword = uw(`MRS_M_CNT_DRV | `MRS_M_O_BUF, `MRS_A_FETCH);
            `MRS_A_OPSEL: o_uword = uw(`MRS_M_IND_TEST | `MRS_M_WAIT_CLK, `MRS_A_EXEC);
            `MRS_A_EXEC: o_uword = uw(`MRS_M_JMP_INC | `MRS_M_DEFER, `MRS_A_IRSEL);
            `MRS_A_IA0: o_uword = uw(`MRS_M_CNT_DRV | `MRS_M_OPR_LD | `MRS_M_CHAIN, `MRS_A_IA0_2);
            `MRS_A_IA0_2: o_uword = uw(`MRS_M_BUF_B | `MRS_M_PLUS1 | `MRS_M_JMP_INC | `MRS_M_CHAIN,
                `MRS_A_IRSEL);
            `MRS_A_SUBR: o_uword = uw(`MRS_M_OPR_DRV | `MRS_M_O_BUF | `MRS_M_DONE | `MRS_M_CHAIN,
                `MRS_A_BEGIN);
            `MRS_A_ISZ: o_uword = uw(`MRS_M_BUF_B | `MRS_M_OPR_LD | `MRS_M_SKIP_SET | `MRS_M_DONE
                | `MRS_M_CHAIN, `MRS_A_BEGIN);
            `MRS_A_JMP: o_uword = uw(`MRS_M_BUF_B | `MRS_M_CNT_LD | `MRS_M_FLAG_CAP | `MRS_M_DONE
                | `MRS_M_CHAIN, `MRS_A_BEGIN);
            default: o_uword = uw(`MRS_M_DONE | `MRS_M_CHAIN, `MRS_A_BEGIN);
        endcase
    end
endmodule : mrs_ctrl_rom

// file: verilog/mrs_sequencer.sv
`timescale 1ns/10ps
`include "mrs_cfg.svh"
// Operation
// - Increment-skip adds one to memory word, stores it, skips on zero.
// - Increment-skip opcode selects word 24, whose next address is 30.
// - Word 30 asserts jump-increment and defer-entry, next 60, waits for memory.
// - Jump-increment gate with increment-skip level carries into adder bit 17.
// - Read-done restarts timing; instruction bits raise 60 to 71.
// - Adder zero level; word 71 latches it and loads operand register.
// - Write back incremented buffer; skip cleared at fetch, set by word 71.
// - Begin word with skip set carries in, incrementing counter into buffer.
// - Jump loads counter with target, directly or after defer.
// - Jump remap selects word 74: buffer to counter, link capture, done.
// - Defer-entry clears indirect bit; the remap of 60 ignores that bit, so indirect jump is remapped too.
// - Word 74 captures link into holding latch; restored when capture falls.
// - Direct subroutine call stores counter and status at Y, continues at Y+1.
// - Indirect-test turns 30 into 32 when bits 0, 1 and 4 are zero.
// - Word 32 drives counter through adder into operand register, next 23.
// - Counter is thirteen low bits; top bits carry link, modes, page bits.
// - Word 23 forms Y+1, loads counter when bits 0, 1, 3 zero, next 60.
// - The memory read during word 23 never reaches the buffer.
// - Bit 2 turns 60 into 62; word 62 writes saved counter into Y.
// - Begin word copies counter into buffer for the next fetch.
module mrs_sequencer #(
    parameter int CMCLK_DIV = `MRS_CMCLK_DIV
) (
    input wire logic I_CLOCK,
    input wire logic I_RESETN,
    input wire logic [11:0] I_PADDR,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic O_MEM_READ,
    output logic O_MEM_WRITE,
    output mrs_pkg::mrs_addr_t O_MEM_ADDR,
    output mrs_pkg::mrs_word_t O_MEM_WDATA,
    input wire mrs_pkg::mrs_word_t I_MEM_RDATA,
    input wire logic I_MEM_DONE,
    output logic O_BUSY
);
    import mrs_pkg::*;

    if (CMCLK_DIV < 2 || CMCLK_DIV > 255) begin : g_chk
        $error("CMCLK_DIV out of range");
    end

    mrs_state_e state_q;
    mrs_cma_t cma_q, pend_q, nxt;
    mrs_uword_t uword;
    logic [14:0] ops;
    logic [3:0] op_q;
    logic ind_q;
    mrs_word_t mb_q, ar_q, rd_s1_q, rd_s2_q, a_bus, b_bus, o_bus;
    mrs_addr_t pc_q, ea_q;
    logic link_q, hold_q, skip_q, zero_q, cap_q, exd_q, prot_q, unsup_q;
    logic [1:0] epc_q;
    logic dn_s1_q, dn_s2_q, dn_s3_q, mem_done;
    logic [7:0] div_q;
    logic cm_clk;
    logic carry, adr_zero, adr_link, run, is_isz, is_jms;
    logic [18:0] sum;
    logic wr_en, wr_instr, start, rd_setup;
    logic [31:0] rdata;

    function automatic logic has(input logic [14:0] u, input logic [14:0] m);
        has = (u & m) != 15'h0000;
    endfunction : has

    // Next address with instruction-bit gating of the control memory address.
    function automatic mrs_cma_t modify(input mrs_cma_t n, input logic [3:0] op, input logic ind,
                                        input logic test);
        mrs_cma_t a;
        a = n;
        if (test && !op[3] && !op[2] && !ind) begin
            a = a | `MRS_MOD_TI;
        end
        if (a[5:4] == `MRS_SEL_HI) begin
            if (op == `MRS_OP_ISZ) begin
                a = a | `MRS_MOD_ISZ;
            end else if (op == `MRS_OP_JMS) begin
                a = a | `MRS_MOD_JMS;
            end else if (op == `MRS_OP_JMP) begin
                a = a | `MRS_MOD_JMP;
            end
        end
        modify = a;
    endfunction : modify

    // ======================================================================
    // Control memory.
    mrs_ctrl_rom u_rom (
        .i_cma(cma_q),
        .o_uword(uword)
    );

    assign ops = uword[14:0];
    assign run = (state_q == MRS_RUN);
    assign is_isz = (op_q == `MRS_OP_ISZ);
    assign is_jms = (op_q == `MRS_OP_JMS);
    assign nxt = modify(uword[20:15], op_q, ind_q, has(ops, `MRS_M_IND_TEST));

    // ======================================================================
    // Buses and adder.
    always_comb begin
        a_bus = '0;
        if (has(ops, `MRS_M_CNT_DRV)) begin
            a_bus = {link_q, exd_q, prot_q, epc_q, pc_q};
        end else if (has(ops, `MRS_M_OPR_DRV)) begin
            a_bus = ar_q;
        end
        b_bus = '0;
        if (state_q == MRS_WMEM) begin
            b_bus = rd_s2_q;
        end else if (has(ops, `MRS_M_BUF_B)) begin
            b_bus = mb_q;
        end
    end

    assign carry = has(ops, `MRS_M_PLUS1) | (has(ops, `MRS_M_JMP_INC) & is_isz)
        | (has(ops, `MRS_M_CNT_DRV) & skip_q);
    assign sum = {1'b0, a_bus} + {1'b0, b_bus} + {18'h00000, carry};
    assign o_bus = sum[17:0];
    assign adr_zero = (o_bus == 18'h00000);
    assign adr_link = link_q ^ sum[18];

    // ======================================================================
    // Memory read-done pulse and read data synchronisers.
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            dn_s1_q <= 1'b0;
            dn_s2_q <= 1'b0;
            dn_s3_q <= 1'b0;
            rd_s1_q <= '0;
            rd_s2_q <= '0;
        end else begin
            dn_s1_q <= I_MEM_DONE;
            dn_s2_q <= dn_s1_q;
            dn_s3_q <= dn_s2_q;
            rd_s1_q <= I_MEM_RDATA;
            rd_s2_q <= rd_s1_q;
        end
    end

    assign mem_done = dn_s2_q & ~dn_s3_q;

    // ======================================================================
    // Control memory clock divider.
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            div_q <= 8'h00;
        end else if (div_q == 8'(CMCLK_DIV - 1)) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    assign cm_clk = (div_q == 8'h00);

    // ======================================================================
    // APB slave.
    assign O_PREADY = 1'b1;
    assign rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;
    assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
    assign wr_instr = wr_en && (I_PADDR == `MRS_R_INSTR);
    assign start = wr_instr && (state_q == MRS_IDLE);

    always_comb begin
        O_PSLVERR = 1'b0;
        if (I_PSEL && I_PENABLE && (I_PADDR != `MRS_R_INSTR) && (I_PADDR != `MRS_R_PC)
            && (I_PADDR != `MRS_R_STATUS) && (I_PADDR != `MRS_R_MODE)) begin
            O_PSLVERR = 1'b1;
        end
    end

    always_comb begin
        rdata = 32'h00000000;
        if (I_PADDR == `MRS_R_INSTR) begin
            rdata = {14'h0000, mb_q};
        end else if (I_PADDR == `MRS_R_PC) begin
            rdata = {19'h00000, pc_q};
        end else if (I_PADDR == `MRS_R_STATUS) begin
            rdata = {18'h00000, cma_q, 2'h0, unsup_q, hold_q, link_q, zero_q, skip_q, O_BUSY};
        end else if (I_PADDR == `MRS_R_MODE) begin
            rdata = {27'h0000000, epc_q, prot_q, exd_q, link_q};
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_PRDATA <= 32'h00000000;
        end else if (rd_setup) begin
            O_PRDATA <= rdata;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            exd_q <= 1'b0;
            prot_q <= 1'b0;
            epc_q <= 2'h0;
        end else if (wr_en && (I_PADDR == `MRS_R_MODE) && (state_q == MRS_IDLE)) begin
            exd_q <= I_PWDATA[1];
            prot_q <= I_PWDATA[2];
            epc_q <= I_PWDATA[4:3];
        end
    end

    // ======================================================================
    // Sequencer.
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_q <= MRS_IDLE;
            cma_q <= `MRS_A_BEGIN;
            pend_q <= `MRS_A_BEGIN;
            unsup_q <= 1'b0;
        end else begin
            case (state_q)
                MRS_IDLE: begin
                    if (wr_instr) begin
                        unsup_q <= 1'b0;
                        if (I_PWDATA[17:14] == `MRS_OP_JMP && !I_PWDATA[13]) begin
                            cma_q <= modify(`MRS_A_IRSEL, `MRS_OP_JMP, 1'b0, 1'b0);
                            state_q <= MRS_RUN;
                        end else if (I_PWDATA[17:14] == `MRS_OP_ISZ || I_PWDATA[17:14] == `MRS_OP_JMS
                                     || I_PWDATA[17:14] == `MRS_OP_JMP) begin
                            cma_q <= `MRS_A_OPSEL;
                            state_q <= MRS_RUN;
                        end else begin
                            unsup_q <= 1'b1;
                        end
                    end
                end
                MRS_RUN: begin
                    pend_q <= nxt;
                    if (cma_q == `MRS_A_BEGIN) begin
                        state_q <= MRS_IDLE;
                    end else if (has(ops, `MRS_M_CHAIN)) begin
                        cma_q <= nxt;
                    end else if (has(ops, `MRS_M_WAIT_CLK)) begin
                        state_q <= MRS_WCLK;
                    end else begin
                        state_q <= MRS_WMEM;
                    end
                end
                MRS_WCLK: begin
                    if (cm_clk) begin
                        cma_q <= pend_q;
                        state_q <= MRS_RUN;
                    end
                end
                MRS_WMEM: begin
                    if (mem_done) begin
                        cma_q <= pend_q;
                        state_q <= MRS_RUN;
                    end
                end
                default: state_q <= MRS_IDLE;
            endcase
        end
    end

    assign O_BUSY = (state_q != MRS_IDLE);

    // ======================================================================
    // Instruction register.
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            op_q <= 4'h0;
            ind_q <= 1'b0;
            ea_q <= '0;
        end else if (start) begin
            op_q <= I_PWDATA[17:14];
            ind_q <= I_PWDATA[13];
            ea_q <= I_PWDATA[12:0];
        end else if (run && has(ops, `MRS_M_DEFER)) begin
            ind_q <= 1'b0;
        end
    end

    // ======================================================================
    // Memory buffer, operand register and zero latch.
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            mb_q <= '0;
        end else if (start) begin
            mb_q <= I_PWDATA[17:0];
        end else if (state_q == MRS_WMEM && mem_done) begin
            mb_q <= o_bus;
        end else if (run && has(ops, `MRS_M_O_BUF)) begin
            mb_q <= o_bus;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ar_q <= '0;
            zero_q <= 1'b0;
        end else if (run && has(ops, `MRS_M_OPR_LD)) begin
            ar_q <= o_bus;
            zero_q <= adr_zero;
        end
    end

    // ======================================================================
    // Program counter.
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pc_q <= '0;
        end else if (wr_en && (I_PADDR == `MRS_R_PC) && (state_q == MRS_IDLE)) begin
            pc_q <= I_PWDATA[12:0];
        end else if (run && (has(ops, `MRS_M_CNT_LD)
                     || (has(ops, `MRS_M_JMP_INC) && !op_q[3] && !op_q[2] && !op_q[0]))) begin
            pc_q <= o_bus[12:0];
        end
    end

    // ======================================================================
    // Skip flip-flop.
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            skip_q <= 1'b0;
        end else if (run && has(ops, `MRS_M_SKIP_SET) && adr_zero && is_isz) begin
            skip_q <= 1'b1;
        end else if (start) begin
            skip_q <= 1'b0;
        end
    end

    // ======================================================================
    // Link and link holding latch.
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            link_q <= 1'b0;
            hold_q <= 1'b0;
            cap_q <= 1'b0;
        end else begin
            if (run) begin
                cap_q <= has(ops, `MRS_M_FLAG_CAP);
            end
            if (run && has(ops, `MRS_M_FLAG_CAP)) begin
                hold_q <= adr_link;
            end
            if (run && cap_q && !has(ops, `MRS_M_FLAG_CAP)) begin
                link_q <= hold_q;
            end else if (wr_en && (I_PADDR == `MRS_R_MODE) && (state_q == MRS_IDLE)) begin
                link_q <= I_PWDATA[0];
            end
        end
    end

    // ======================================================================
    // Core memory half-cycle requests.
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_MEM_READ <= 1'b0;
            O_MEM_WRITE <= 1'b0;
        end else begin
            O_MEM_READ <= run && has(ops, `MRS_M_JMP_INC);
            O_MEM_WRITE <= run && has(ops, `MRS_M_DONE) && (is_isz || is_jms);
        end
    end

    assign O_MEM_ADDR = ea_q;
    assign O_MEM_WDATA = mb_q;
endmodule : mrs_sequencer

// file: tb/mrs_sequencer_properties.sv
`timescale 1ns/10ps
`include "mrs_cfg.svh"
// ====
// Sequencer port checks.
module mrs_sequencer_properties #(
    parameter int CMCLK_DIV = 4
) (
    input wire logic I_CLOCK,
    input wire logic I_RESETN,
    input wire logic [11:0] I_PADDR,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [31:0] I_PWDATA,
    input wire logic O_PREADY,
    input wire logic O_MEM_READ,
    input wire logic O_MEM_WRITE,
    input wire mrs_pkg::mrs_addr_t O_MEM_ADDR,
    input wire mrs_pkg::mrs_word_t O_MEM_WDATA,
    input wire mrs_pkg::mrs_word_t I_MEM_RDATA,
    input wire logic I_MEM_DONE,
    input wire logic O_BUSY
);
    import mrs_pkg::*;
    localparam int JMS_MAX = CMCLK_DIV + 8;
    logic [3:0] op_q;
    logic ind_q;
    mrs_addr_t adr_q;
    logic [2:0] md_q;
    mrs_word_t cap_q;
    mrs_word_t inc_w;
    logic dn_q;
    logic wr_w;
    assign wr_w = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && !O_BUSY;
    assign inc_w = cap_q + 18'h1;
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            op_q <= 4'h0;
            ind_q <= 1'b0;
            adr_q <= 13'h0;
        end else if (wr_w && I_PADDR == `MRS_R_INSTR) begin
            op_q <= I_PWDATA[17:14];
            ind_q <= I_PWDATA[13];
            adr_q <= I_PWDATA[12:0];
        end
    end
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            md_q <= 3'h0;
        end else if (wr_w && I_PADDR == `MRS_R_MODE) begin
            md_q <= I_PWDATA[2:0];
        end
    end
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            dn_q <= 1'b0;
            cap_q <= 18'h0;
        end else begin
            dn_q <= I_MEM_DONE;
            if (I_MEM_DONE && !dn_q) begin
                cap_q <= I_MEM_RDATA;
            end
        end
    end
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RESETN);
    isz_incr_a: assert property (O_MEM_WRITE && op_q == `MRS_OP_ISZ |-> O_MEM_WDATA == inc_w)
        else $error("increment write value wrong");
    isz_wait_a: assert property (O_MEM_READ && op_q == `MRS_OP_ISZ |-> !O_MEM_WRITE [*3])
        else $error("write before read done");
    wr_addr_a: assert property (O_MEM_WRITE && !ind_q |-> O_MEM_ADDR == adr_q)
        else $error("write address wrong");
    jmp_nowr_a: assert property (O_BUSY && op_q == `MRS_OP_JMP |-> !O_MEM_WRITE)
        else $error("jump wrote memory");
    jmp_direct_a: assert property (O_BUSY && op_q == `MRS_OP_JMP && !ind_q |-> !O_MEM_READ)
        else $error("direct jump read memory");
    jmp_short_a: assert property ($rose(O_BUSY) && op_q == `MRS_OP_JMP && !ind_q |-> ##[1:6] !O_BUSY)
        else $error("direct jump too long");
    jms_save_a: assert property (O_MEM_WRITE && op_q == `MRS_OP_JMS |->
        O_MEM_WDATA[17:15] == {md_q[0], md_q[1], md_q[2]})
        else $error("saved status bits wrong");
    rd_busy_a: assert property (O_MEM_READ |-> O_BUSY ##1 !O_MEM_READ)
        else $error("read pulse outside sequence");
    addr_hold_a: assert property (O_BUSY && $past(O_BUSY) |-> $stable(O_MEM_ADDR))
        else $error("address moved in sequence");
    jms_len_a: assert property ($rose(O_BUSY) && op_q == `MRS_OP_JMS && !ind_q |-> ##[1:JMS_MAX] !O_BUSY)
        else $error("direct subroutine call too long");
    isz_c: cover property (O_MEM_WRITE && op_q == `MRS_OP_ISZ && O_MEM_WDATA == 18'h0);
    jms_c: cover property (O_MEM_WRITE && op_q == `MRS_OP_JMS);
    jmpi_c: cover property (O_MEM_READ && op_q == `MRS_OP_JMP);
endmodule : mrs_sequencer_properties
bind mrs_sequencer mrs_sequencer_properties #(.CMCLK_DIV(CMCLK_DIV)) u_props (.I_CLOCK(I_CLOCK),
    .I_RESETN(I_RESETN), .I_PADDR(I_PADDR), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
    .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .O_MEM_READ(O_MEM_READ), .O_MEM_WRITE(O_MEM_WRITE),
    .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA), .I_MEM_RDATA(I_MEM_RDATA), .I_MEM_DONE(I_MEM_DONE),
    .O_BUSY(O_BUSY));

// file: tb/mrs_core_mem_model.sv
`timescale 1ns/10ps
// ====
// Core memory with a delayed read-done pulse.
module mrs_core_mem_model (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_read,
    input wire logic i_write,
    input wire mrs_pkg::mrs_addr_t i_addr,
    input wire mrs_pkg::mrs_word_t i_wdata,
    input wire logic [3:0] i_lat,
    output mrs_pkg::mrs_word_t o_rdata,
    output logic o_done
);
    import mrs_pkg::*;
    mrs_word_t mem [0:8191];
    logic [4:0] cnt_q;
    logic [2:0] hold_q;
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= 5'h00;
            hold_q <= 3'h0;
            o_done <= 1'b0;
            o_rdata <= 18'h2AAAA;
        end else begin
            if (i_write) begin
                mem[i_addr] <= i_wdata;
            end
            if (i_read) begin
                cnt_q <= {1'b0, i_lat} + 5'h02;
            end else if (cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
            end
            if (cnt_q == 5'h02) begin
                o_rdata <= mem[i_addr];
            end
            if (cnt_q == 5'h01) begin
                o_done <= 1'b1;
                hold_q <= 3'h4;
            end else if (hold_q == 3'h1) begin
                o_done <= 1'b0;
                o_rdata <= ~o_rdata;
                hold_q <= 3'h0;
            end else if (hold_q != 3'h0) begin
                hold_q <= hold_q - 3'h1;
            end
        end
    end
endmodule : mrs_core_mem_model

// file: tb/tb_mem_ref_microsequence_isz_jmp_jms.sv
`timescale 1ns/10ps
`include "mrs_cfg.svh"
// ====
// Self-checking bench for the sequencer.
module tb_mem_ref_microsequence_isz_jmp_jms;
    import mrs_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, mem_rd, mem_wr, mem_done, busy;
    mrs_addr_t mem_addr;
    mrs_word_t mem_wdata, mem_rdata;
    logic [3:0] lat = 4'h0;
    logic [64:0] rd_q[$];
    logic [30:0] wr_q[$];
    int num_errors = 0, n_compared = 0, cyc = 0, seed = 62269;
    mrs_sequencer #(.CMCLK_DIV(3)) DUT (.I_CLOCK(clock), .I_RESETN(resetn), .I_PADDR(paddr), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_MEM_READ(mem_rd), .O_MEM_WRITE(mem_wr), .O_MEM_ADDR(mem_addr),
        .O_MEM_WDATA(mem_wdata), .I_MEM_RDATA(mem_rdata), .I_MEM_DONE(mem_done), .O_BUSY(busy));
    mrs_core_mem_model u_mem (.i_clock(clock), .i_resetn(resetn), .i_read(mem_rd), .i_write(mem_wr),
        .i_addr(mem_addr), .i_wdata(mem_wdata), .i_lat(lat), .o_rdata(mem_rdata), .o_done(mem_done));
    initial begin
        forever #2.5 clock = ~clock;
    end
    task automatic report_and_stop();
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic er);
        rd_q.push_back({er, m, e});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic run(input logic [3:0] op, input logic ind, input mrs_addr_t a, input logic poke);
        apb(1'b1, `MRS_R_INSTR, {14'h0, op, ind, a});
        if (poke) apb(1'b1, `MRS_R_PC, 32'h1FFF);
        repeat (2) @(posedge clock);
        while (busy !== 1'b0) @(posedge clock);
    endtask : run
    task automatic cmp_rd(input logic [64:0] n);
        n_compared++;
        if ({pslverr, prdata & n[63:32]} !== {n[64], n[31:0]}) begin
            num_errors++;
            $display("unexpected read at %0t: %h not %h", $time, {pslverr, prdata}, {n[64], n[31:0]});
        end
    endtask : cmp_rd
    task automatic cmp_wr(input logic [30:0] n);
        n_compared++;
        if ({mem_addr, mem_wdata} !== n) begin
            num_errors++;
            $display("unexpected write at %0t: %h not %h", $time, {mem_addr, mem_wdata}, n);
        end
    endtask : cmp_wr
    always @(posedge clock) begin
        if (psel && penable && !pwrite && pready === 1'b1) cmp_rd(rd_q.pop_front());
        if (mem_wr === 1'b1) cmp_wr(wr_q.pop_front());
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        mrs_word_t v, w;
        mrs_addr_t p, a;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        rd(`MRS_R_PC, 32'hFFFFFFFF, 32'h0, 1'b0);
        rd(`MRS_R_MODE, 32'hFFFFFFFF, 32'h0, 1'b0);
        rd(12'h010, 32'hFFFFFFFF, 32'h0, 1'b1);
        p = 13'($random(seed)) & 13'h0FFF;
        apb(1'b1, `MRS_R_PC, {19'h0, p});
        for (int k = 0; k < 3; k++) begin
            a = 13'($random(seed));
            v = (k == 1) ? (18'($random(seed)) & 18'h1FFFF) : 18'h3FFFF;
            w = v + 18'h1;
            lat <= 4'(k * 6);
            u_mem.mem[a] = v;
            wr_q.push_back({a, w});
            run(`MRS_OP_ISZ, 1'b0, a, k == 1);
            rd(`MRS_R_INSTR, 32'h3FFFF, {19'h0, p + 13'(k != 1)}, 1'b0);
            rd(`MRS_R_STATUS, 32'h6, (k == 1) ? 32'h0 : 32'h6, 1'b0);
        end
        rd(`MRS_R_PC, 32'h1FFF, {19'h0, p}, 1'b0);
        apb(1'b1, `MRS_R_MODE, 32'h1F);
        a = 13'($random(seed)) & 13'h0FFF;
        u_mem.mem[a] = 18'h3FFFF;
        wr_q.push_back({a, 5'h1F, p});
        run(`MRS_OP_JMS, 1'b0, a, 1'b0);
        rd(`MRS_R_PC, 32'h1FFF, {19'h0, a + 13'h1}, 1'b0);
        rd(`MRS_R_INSTR, 32'h1FFF, {19'h0, a + 13'h1}, 1'b0);
        for (int k = 0; k < 2; k++) begin
            a = 13'($random(seed));
            v = 18'($random(seed));
            u_mem.mem[a] = v;
            run(`MRS_OP_JMP, k[0], a, 1'b0);
            rd(`MRS_R_PC, 32'h1FFF, {19'h0, k[0] ? v[12:0] : a}, 1'b0);
        end
        rd(`MRS_R_MODE, 32'h1F, 32'h1F, 1'b0);
        run(4'h5, 1'b0, 13'h0, 1'b0);
        rd(`MRS_R_STATUS, 32'h20, 32'h20, 1'b0);
        @(posedge clock);
        if (rd_q.size() != 0 || wr_q.size() != 0) num_errors++;
        report_and_stop();
    end
endmodule : tb_mem_ref_microsequence_isz_jmp_jms
